// ===== src/ebsp_pkg.sv
// Constants and types of the external bus sizing and pseudo-static RAM block
package ebsp_pkg;

	// ****************************************
	// Register offsets in the peripheral register block
	// ****************************************
	localparam logic [7:0] OFS_LOW_MEMORY_SELECT_CONTROL = 8'ha2;
	localparam logic [7:0] OFS_REFRESH_CLOCK_PRESCALER = 8'he2;
	localparam logic [7:0] OFS_REFRESH_UNIT_ENABLE = 8'he4;
	localparam logic [7:0] OFS_AUXILIARY_CONFIGURATION = 8'hf2;

	// ****************************************
	// Reset values, field positions and the minimum refresh reload value
	// ****************************************
	localparam logic [15:0] LOWSEL_CTL_RST = 16'h0000;
	localparam logic [15:0] REF_PRESCALE_RST = 16'h0000;
	localparam logic [15:0] REF_UNIT_RST = 16'h0000;
	localparam logic [15:0] AUX_RST = 16'h0000;
	localparam int WAIT_COUNT_LSB = 0;
	localparam int IGNORE_READY_BIT = 2;
	localparam int PSEUDO_STATIC_BIT = 6;
	localparam int UNIT_ENABLE_BIT = 15;
	localparam int OTHER_WIDTH_BIT = 0;
	localparam int IO_WIDTH_BIT = 1;
	localparam int LOW_WIDTH_BIT = 2;
	localparam logic [15:0] REFRESH_RELOAD_MIN = 16'h0012;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 25;
	localparam int PSRAM_ACCESS_NS = 70;
	localparam int PRECHARGE_NS = 25;
	localparam int REFRESH_NS = 50;
	localparam logic [3:0] PRE_TICKS = 4'((PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] REF_TICKS = 4'((REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ****************************************
	// Address spaces and bus states
	// ****************************************
	typedef enum logic [1:0] {
		SP_UPPER = 2'h0,
		SP_LOW = 2'h1,
		SP_IO = 2'h2,
		SP_OTHER = 2'h3
	} ebsp_space_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_T1 = 4'h2,
		ST_T2 = 4'h3,
		ST_TW = 4'h4,
		ST_T3 = 4'h5,
		ST_T4 = 4'h6,
		ST_PRE = 4'h7,
		ST_RF = 4'h8
	} ebsp_state_t;

endpackage

// ===== src/ebsp_refresh_strobe_if.sv
// Link between the bus sequencer and its refresh interval counter
interface ebsp_refresh_strobe_if;
	logic [15:0] reload;
	logic run;
	logic expire;
	logic [15:0] count;

	modport ctl (output reload, output run, input expire, input count);
	modport cnt (input reload, input run, output expire, output count);
endinterface

// ===== src/ebsp_reload_counter.sv
// Reloading down counter that paces refresh cycles
module ebsp_reload_counter #(
	parameter int W = 16
) (
	input wire logic ref_clk_i, // Clock
	input wire logic arst_n_i, // Asynchronous reset, active low
	ebsp_refresh_strobe_if.cnt rf // Reload value, run, expiry
);

	typedef struct packed {
		logic [W-1:0] count;
		logic expire;
	} ebsp_cnt_t;

	ebsp_cnt_t s_ff;
	ebsp_cnt_t nxt_s;

	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.expire = 1'b0;
		if (!rf.run)
		begin
			nxt_s.count = rf.reload[W-1:0];
		end
		else if (s_ff.count == '0)
		begin
			nxt_s.expire = 1'b1;
			nxt_s.count = rf.reload[W-1:0];
		end
		else
		begin
			nxt_s.count = s_ff.count - W'(1);
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign rf.expire = s_ff.expire;
	assign rf.count = 16'(s_ff.count);

	a_expire_reload: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		(rf.run && s_ff.count == '0) |=> (s_ff.expire && s_ff.count == $past(rf.reload[W-1:0])))
		else $error("Counter did not expire and reload");

endmodule

// ===== src/ebsp_top.sv
// Bus sequencer with early address, bus sizing, byte enables and pseudo-static refresh
// Notes on behaviour
// - Address bus is valid one clock before address appears on the data bus.
// - Wide part: low, I/O and other spaces select 8 or 16 bits; upper fixed.
// - Narrow part: every access uses the 8-bit bus, not programmable.
// - High-byte write enable is byte-high-enable OR write strobe, active low.
// - Low-byte write enable is address bit zero OR write strobe, active low.
// - Narrow part: byte write strobe low on each byte write, early, floats in reset.
// - Byte write enables move together with the address bus.
// - Pseudo-static mode applies to low space only and inserts a select precharge.
// - Pseudo-static mode bit lives in the low space control register, cleared on reset.
// - Timing lets 70 ns pseudo-static RAM run with one wait state.
// - Only auto refresh; strobe when mode and refresh unit enabled; no row address.
// - Refresh strobe shares the midrange select three pin, no select in that mode.
// - During refresh the low select stays high and the address bus is unused.
// - Control registers are 16 bits, addressed within one 256-byte block.
// - Narrow part: a byte write to a control register transfers all 16 bits.
module ebsp_top #(
	parameter bit WIDE_BUS = 1'b1
) (
	input wire logic ref_clk_i, // Processor clock
	input wire logic arst_n_i, // Asynchronous reset, active low
	input wire logic cyc_req_i, // Bus cycle request from the core
	input wire logic [19:0] cyc_addr_i, // Cycle address
	input wire logic cyc_write_i, // Cycle is a write
	input wire logic cyc_bhe_n_i, // Byte high enable, active low
	input wire logic [1:0] cyc_space_i, // Address space of the cycle
	input wire logic cyc_mid3_i, // Cycle hits midrange select three
	input wire logic [15:0] cyc_wdata_i, // Write data
	output logic cyc_busy_o, // Cycle in progress
	output logic cyc_done_o, // Cycle finished pulse
	output logic [15:0] cyc_rdata_o, // Read data
	input wire logic pcb_sel_i, // Register block access
	input wire logic pcb_wr_i, // Register write
	input wire logic pcb_byte_i, // Register byte write
	input wire logic [7:0] pcb_offset_i, // Register offset
	input wire logic [15:0] pcb_wdata_i, // Register write data
	output logic [15:0] pcb_rdata_o, // Register read data
	output logic [19:0] a_bus_o, // Nonmultiplexed address
	output logic a_bus_oe_n_o, // Address bus enable, active low
	output logic [15:0] ad_o, // Multiplexed address/data out
	output logic ad_oe_n_o, // Address/data enable, active low
	input wire logic [15:0] ad_i, // Address/data pin in
	input wire logic ready_i, // External ready pin
	output logic bhe_n_o, // Byte high enable pin
	output logic wr_n_o, // Write strobe pin
	output logic high_byte_write_enable_n_o, // High byte write enable
	output logic low_byte_write_enable_n_o, // Low byte write enable
	output logic byte_write_strobe_n_o, // Narrow part byte write strobe
	output logic byte_write_strobe_oe_n_o, // Byte write strobe enable, active low
	output logic low_memory_select_n_o, // Low space select
	output logic midrange_select_three_n_o, // Select three or refresh strobe
	output logic bus_width8_o // Current cycle uses 8-bit bus
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		ebsp_pkg::ebsp_state_t st;
		logic [3:0] wcnt;
		logic [19:0] a_bus;
		logic a_oe_n;
		logic [15:0] ad;
		logic ad_oe_n;
		logic bhe_n;
		logic wr_n;
		logic whb_n;
		logic wlb_n;
		logic wb_n;
		logic wb_oe_n;
		logic lcs_n;
		logic m3r_n;
		logic w8;
		logic busy;
		logic done;
		logic write;
		logic low_ps;
		logic ign_rdy;
		logic [15:0] rdata;
		logic [15:0] pcb_rdata;
		logic [15:0] low_memory_select_control;
		logic [15:0] refresh_clock_prescaler;
		logic [15:0] refresh_control_unit;
		logic [15:0] aux;
		logic rf_pend;
		logic rdy_s1;
		logic rdy_s2;
		logic [15:0] ad_s1;
		logic [15:0] ad_s2;
	} ebsp_state_reg_t;

	localparam ebsp_state_reg_t RST_STATE = '{
		st: ebsp_pkg::ST_IDLE,
		a_oe_n: 1'b1,
		ad_oe_n: 1'b1,
		bhe_n: 1'b1,
		wr_n: 1'b1,
		whb_n: 1'b1,
		wlb_n: 1'b1,
		wb_n: 1'b1,
		wb_oe_n: 1'b1,
		lcs_n: 1'b1,
		m3r_n: 1'b1,
		low_memory_select_control: ebsp_pkg::LOWSEL_CTL_RST,
		refresh_clock_prescaler: ebsp_pkg::REF_PRESCALE_RST,
		refresh_control_unit: ebsp_pkg::REF_UNIT_RST,
		aux: ebsp_pkg::AUX_RST,
		default: '0
	};

	ebsp_state_reg_t s_ff;
	ebsp_state_reg_t nxt_s;
	ebsp_refresh_strobe_if rf ();
	logic pseudo_static_mode_enable;
	logic rf_run;
	logic rdy_ok;
	logic narrow;
	logic [15:0] wval;

	ebsp_reload_counter #(
		.W(16)
	) u_refresh_strobe_cnt (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.rf(rf)
	);

	assign pseudo_static_mode_enable = s_ff.low_memory_select_control[ebsp_pkg::PSEUDO_STATIC_BIT];
	assign rf_run = pseudo_static_mode_enable && s_ff.refresh_control_unit[ebsp_pkg::UNIT_ENABLE_BIT];
	assign rf.run = rf_run;
	assign rf.reload = s_ff.refresh_clock_prescaler;

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.rdy_s1 = ready_i;
		nxt_s.rdy_s2 = s_ff.rdy_s1;
		nxt_s.ad_s1 = ad_i;
		nxt_s.ad_s2 = s_ff.ad_s1;
		nxt_s.done = 1'b0;
		nxt_s.wb_oe_n = 1'b0;
		rdy_ok = s_ff.ign_rdy || s_ff.rdy_s2;
		narrow = 1'b0;
		// Byte writes on the narrow part carry the whole word
		if (WIDE_BUS && pcb_byte_i)
			wval = {16'h0000};
		else
			wval = pcb_wdata_i;
		// Register block, aligned accesses only
		if (pcb_sel_i && !pcb_offset_i[0])
		begin
			if (pcb_wr_i)
			begin
				case (pcb_offset_i)
					ebsp_pkg::OFS_LOW_MEMORY_SELECT_CONTROL:
						nxt_s.low_memory_select_control = (WIDE_BUS && pcb_byte_i) ? {s_ff.low_memory_select_control[15:8], pcb_wdata_i[7:0]} : wval;
					ebsp_pkg::OFS_REFRESH_CLOCK_PRESCALER:
						nxt_s.refresh_clock_prescaler = (WIDE_BUS && pcb_byte_i) ? {s_ff.refresh_clock_prescaler[15:8], pcb_wdata_i[7:0]} : wval;
					ebsp_pkg::OFS_REFRESH_UNIT_ENABLE:
						nxt_s.refresh_control_unit = (WIDE_BUS && pcb_byte_i) ? {s_ff.refresh_control_unit[15:8], pcb_wdata_i[7:0]} : wval;
					ebsp_pkg::OFS_AUXILIARY_CONFIGURATION:
						nxt_s.aux = (WIDE_BUS && pcb_byte_i) ? {s_ff.aux[15:8], pcb_wdata_i[7:0]} : wval;
					default:
						nxt_s.pcb_rdata = s_ff.pcb_rdata;
				endcase
			end
			else
			begin
				case (pcb_offset_i)
					ebsp_pkg::OFS_LOW_MEMORY_SELECT_CONTROL:
						nxt_s.pcb_rdata = s_ff.low_memory_select_control;
					ebsp_pkg::OFS_REFRESH_CLOCK_PRESCALER:
						nxt_s.pcb_rdata = s_ff.refresh_clock_prescaler;
					ebsp_pkg::OFS_REFRESH_UNIT_ENABLE:
						nxt_s.pcb_rdata = {s_ff.refresh_control_unit[ebsp_pkg::UNIT_ENABLE_BIT], rf.count[14:0]};
					ebsp_pkg::OFS_AUXILIARY_CONFIGURATION:
						nxt_s.pcb_rdata = s_ff.aux;
					default:
						nxt_s.pcb_rdata = 16'h0000;
				endcase
			end
		end
		// Bus sequencer
		case (s_ff.st)
			ebsp_pkg::ST_IDLE:
			begin
				if (s_ff.rf_pend && rf_run)
				begin
					nxt_s.st = ebsp_pkg::ST_RF;
					nxt_s.wcnt = ebsp_pkg::REF_TICKS - 4'h1;
					nxt_s.rf_pend = 1'b0;
					nxt_s.busy = 1'b1;
					nxt_s.m3r_n = 1'b0;
					nxt_s.lcs_n = 1'b1;
					nxt_s.a_oe_n = 1'b1;
				end
				else if (cyc_req_i)
				begin
					nxt_s.st = ebsp_pkg::ST_ADDR;
					nxt_s.busy = 1'b1;
					nxt_s.write = cyc_write_i;
					nxt_s.a_bus = cyc_addr_i;
					nxt_s.a_oe_n = 1'b0;
					nxt_s.bhe_n = cyc_bhe_n_i;
					nxt_s.wr_n = !cyc_write_i;
					nxt_s.lcs_n = (cyc_space_i != ebsp_pkg::SP_LOW);
					nxt_s.m3r_n = pseudo_static_mode_enable ? 1'b1 : !cyc_mid3_i;
					nxt_s.low_ps = pseudo_static_mode_enable && (cyc_space_i == ebsp_pkg::SP_LOW);
					nxt_s.ign_rdy = (cyc_space_i != ebsp_pkg::SP_LOW) || s_ff.low_memory_select_control[ebsp_pkg::IGNORE_READY_BIT];
					case (cyc_space_i)
						ebsp_pkg::SP_LOW:
							narrow = s_ff.aux[ebsp_pkg::LOW_WIDTH_BIT];
						ebsp_pkg::SP_IO:
							narrow = s_ff.aux[ebsp_pkg::IO_WIDTH_BIT];
						ebsp_pkg::SP_OTHER:
							narrow = s_ff.aux[ebsp_pkg::OTHER_WIDTH_BIT];
						default:
							narrow = 1'b0;
					endcase
					nxt_s.w8 = !WIDE_BUS || narrow;
				end
			end
			ebsp_pkg::ST_ADDR:
			begin
				nxt_s.ad = s_ff.a_bus[15:0];
				nxt_s.ad_oe_n = 1'b0;
				nxt_s.st = ebsp_pkg::ST_T1;
			end
			ebsp_pkg::ST_T1:
			begin
				nxt_s.ad = cyc_wdata_i;
				nxt_s.ad_oe_n = !s_ff.write;
				nxt_s.wcnt = (s_ff.lcs_n) ? 4'h0 : {2'b00, s_ff.low_memory_select_control[ebsp_pkg::WAIT_COUNT_LSB +: 2]};
				nxt_s.st = ebsp_pkg::ST_T2;
			end
			ebsp_pkg::ST_T2:
			begin
				if (s_ff.wcnt != 4'h0 || !rdy_ok)
					nxt_s.st = ebsp_pkg::ST_TW;
				else
					nxt_s.st = ebsp_pkg::ST_T3;
			end
			ebsp_pkg::ST_TW:
			begin
				if (s_ff.wcnt > 4'h1)
					nxt_s.wcnt = s_ff.wcnt - 4'h1;
				else if (rdy_ok)
					nxt_s.st = ebsp_pkg::ST_T3;
			end
			ebsp_pkg::ST_T3:
			begin
				nxt_s.st = ebsp_pkg::ST_T4;
			end
			ebsp_pkg::ST_T4:
			begin
				if (!s_ff.write)
					nxt_s.rdata = s_ff.ad_s2;
				nxt_s.wr_n = 1'b1;
				nxt_s.bhe_n = 1'b1;
				nxt_s.lcs_n = 1'b1;
				nxt_s.m3r_n = 1'b1;
				nxt_s.ad_oe_n = 1'b1;
				nxt_s.done = 1'b1;
				if (s_ff.low_ps)
				begin
					nxt_s.st = ebsp_pkg::ST_PRE;
					nxt_s.wcnt = ebsp_pkg::PRE_TICKS - 4'h1;
				end
				else
				begin
					nxt_s.st = ebsp_pkg::ST_IDLE;
					nxt_s.busy = 1'b0;
				end
			end
			ebsp_pkg::ST_PRE:
			begin
				if (s_ff.wcnt == 4'h0)
				begin
					nxt_s.st = ebsp_pkg::ST_IDLE;
					nxt_s.busy = 1'b0;
				end
				else
					nxt_s.wcnt = s_ff.wcnt - 4'h1;
			end
			ebsp_pkg::ST_RF:
			begin
				if (s_ff.wcnt == 4'h0)
				begin
					nxt_s.st = ebsp_pkg::ST_IDLE;
					nxt_s.busy = 1'b0;
					nxt_s.m3r_n = 1'b1;
				end
				else
					nxt_s.wcnt = s_ff.wcnt - 4'h1;
			end
			default:
			begin
				nxt_s.st = ebsp_pkg::ST_IDLE;
				nxt_s.busy = 1'b0;
			end
		endcase
		// Expiry wins over the clear taken when the refresh cycle starts
		if (rf.expire && rf_run)
			nxt_s.rf_pend = 1'b1;
		else if (!rf_run)
			nxt_s.rf_pend = 1'b0;
		nxt_s.whb_n = nxt_s.bhe_n | nxt_s.wr_n;
		nxt_s.wlb_n = nxt_s.a_bus[0] | nxt_s.wr_n;
		nxt_s.wb_n = WIDE_BUS ? 1'b1 : nxt_s.wr_n;
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			s_ff <= RST_STATE;
		else
			s_ff <= nxt_s;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign cyc_busy_o = s_ff.busy;
	assign cyc_done_o = s_ff.done;
	assign cyc_rdata_o = s_ff.rdata;
	assign pcb_rdata_o = s_ff.pcb_rdata;
	assign a_bus_o = s_ff.a_bus;
	assign a_bus_oe_n_o = s_ff.a_oe_n;
	assign ad_o = s_ff.ad;
	assign ad_oe_n_o = s_ff.ad_oe_n;
	assign bhe_n_o = s_ff.bhe_n;
	assign wr_n_o = s_ff.wr_n;
	assign high_byte_write_enable_n_o = s_ff.whb_n;
	assign low_byte_write_enable_n_o = s_ff.wlb_n;
	assign byte_write_strobe_n_o = s_ff.wb_n;
	assign byte_write_strobe_oe_n_o = s_ff.wb_oe_n;
	assign low_memory_select_n_o = s_ff.lcs_n;
	assign midrange_select_three_n_o = s_ff.m3r_n;
	assign bus_width8_o = s_ff.w8;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_ps_wait1;
		s_ff.st == ebsp_pkg::ST_T2 && s_ff.low_ps && s_ff.wcnt == 4'h1;
	endsequence

	sequence s_ps_tail;
		s_ff.st == ebsp_pkg::ST_TW ##1 s_ff.st == ebsp_pkg::ST_T3 ##1 s_ff.st == ebsp_pkg::ST_T4
			##1 (s_ff.st == ebsp_pkg::ST_PRE && low_memory_select_n_o);
	endsequence

	a_addr_lead: assert property (s_ff.st == ebsp_pkg::ST_ADDR && !a_bus_oe_n_o |=>
		(!ad_oe_n_o && ad_o == $past(a_bus_o[15:0]) && a_bus_o == $past(a_bus_o)))
		else $error("Address bus did not lead the data bus");
	a_whb_both_low: assert property (!high_byte_write_enable_n_o |-> (!bhe_n_o && !wr_n_o))
		else $error("High byte enable low without both inputs low");
	a_wlb_both_low: assert property (!low_byte_write_enable_n_o |-> (!a_bus_o[0] && !wr_n_o))
		else $error("Low byte enable low without both inputs low");
	a_enables_early: assert property ((s_ff.st == ebsp_pkg::ST_IDLE && cyc_req_i && cyc_write_i
		&& !cyc_addr_i[0] && !(s_ff.rf_pend && rf_run)) |=> (!low_byte_write_enable_n_o && a_bus_o == $past(cyc_addr_i)))
		else $error("Byte enable not driven with the address");
	a_upper_wide: assert property ((s_ff.st == ebsp_pkg::ST_IDLE && cyc_req_i && cyc_space_i == ebsp_pkg::SP_UPPER
		&& !(s_ff.rf_pend && rf_run)) |=> (bus_width8_o == !WIDE_BUS))
		else $error("Upper space width wrong");
	a_narrow_all: assert property (cyc_busy_o && !WIDE_BUS && s_ff.st != ebsp_pkg::ST_RF |-> bus_width8_o)
		else $error("Narrow part used a wide bus");
	a_wb_strobe: assert property (!WIDE_BUS && s_ff.st == ebsp_pkg::ST_ADDR && s_ff.write
		|-> !byte_write_strobe_n_o ##1 !byte_write_strobe_n_o)
		else $error("Byte write strobe missing");
	a_psram_precharge: assert property (s_ps_wait1 |=> s_ps_tail)
		else $error("Pseudo-static access did not take one wait and precharge");
	a_refresh_pulse: assert property ((s_ff.st == ebsp_pkg::ST_IDLE && s_ff.rf_pend && rf_run)
		|=> (!midrange_select_three_n_o && low_memory_select_n_o && a_bus_oe_n_o)[*2]
		##1 midrange_select_three_n_o)
		else $error("Refresh cycle malformed");
	a_refresh_gate: assert property (s_ff.st == ebsp_pkg::ST_RF |-> rf_run)
		else $error("Refresh without mode and unit enabled");
	a_pse_no_select: assert property (pseudo_static_mode_enable && s_ff.st == ebsp_pkg::ST_ADDR |-> midrange_select_three_n_o)
		else $error("Select three asserted in pseudo-static mode");

endmodule

// ===== tb/ebsp_mem_model.sv
// Behavioural static memory on the far side of the external bus
module ebsp_mem_model (
	input wire logic ref_clk_i, // Clock
	input wire logic [19:0] a_bus_i, // Address bus
	input wire logic a_oe_n_i, // Address bus enable, active low
	input wire logic [15:0] ad_i, // Address/data from device
	input wire logic ad_oe_n_i, // Address/data enable, active low
	input wire logic wr_n_i, // Write strobe
	input wire logic hwe_n_i, // High byte write enable
	input wire logic lwe_n_i, // Low byte write enable
	input wire logic lcs_n_i, // Low space select
	input wire logic slow_i, // Hold ready low early in low space cycles
	output logic [15:0] ad_o, // Read data to device
	output logic ready_o // Ready
);
	logic [15:0] mem [16] = '{default: 16'h0000};
	logic [15:0] last_ff = 16'h0000;
	logic [1:0] age_ff = 2'h3;

	always @(posedge ref_clk_i)
	begin
		if (!ad_oe_n_i && !wr_n_i && !hwe_n_i)
			mem[a_bus_i[4:1]][15:8] <= ad_i[15:8];
		if (!ad_oe_n_i && !wr_n_i && !lwe_n_i)
			mem[a_bus_i[4:1]][7:0] <= ad_i[7:0];
		last_ff <= ad_o;
		// Ready is low for the first three cycles of a select
		age_ff <= lcs_n_i ? 2'h0 : ((age_ff == 2'h3) ? age_ff : age_ff + 2'h1);
	end

	// Released lines show a changing pattern, not the old data
	always_comb
		ad_o = (!a_oe_n_i && wr_n_i && ad_oe_n_i) ? mem[a_bus_i[4:1]] : ~last_ff;
	assign ready_o = !slow_i || age_ff == 2'h3;
endmodule

// ===== tb/ebsp_top_tb_top.sv
// Self-checking bench of the bus sequencer with a static memory model
module ebsp_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [1:0] sp; logic w; logic bhe_n; logic mid3; logic [19:0] adr; logic [15:0] wd;} ebsp_row_t;
	logic ref_clk_i = 1'b0, arst_n_i = 1'b0, cyc_req = 1'b0, cyc_write = 1'b0, cyc_bhe_n = 1'b1, cyc_mid3 = 1'b0;
	logic pcb_sel = 1'b0, pcb_wr = 1'b0, pcb_byte = 1'b0, slow = 1'b0, pseudo_static_mode_enable = 1'b0, bz;
	logic [1:0] cyc_space = 2'h0;
	logic [19:0] cyc_addr = 20'h00000, a_bus;
	logic [15:0] cyc_wdata = 16'h0000, pcb_wdata = 16'h0000, ad_in, rd, cyc_rdata, pcb_rdata, ad_out;
	logic [7:0] pcb_offset = 8'h00;
	logic [2:0] aux = 3'h6;
	logic busy, done, a_oe_n, ad_oe_n, bhe_n, wr_n, hwe_n, lwe_n, wb_n, wb_oe_n, lsel_n, mid3_n, w8, ready;
	logic w8n, wb8_n;
	logic [15:0] rd8, pcb_rdata8;
	int miscompares = 0, n_tests = 0, cycles = 0, n, n0, t, k;
	ebsp_row_t rows [8] = '{
		'{2'h0, 1'b1, 1'b0, 1'b0, 20'h00010, 16'ha55a}, '{2'h3, 1'b1, 1'b1, 1'b0, 20'h40012, 16'h1234},
		'{2'h2, 1'b1, 1'b0, 1'b0, 20'h00015, 16'hbeef}, '{2'h1, 1'b1, 1'b0, 1'b0, 20'h00006, 16'hc3c3},
		'{2'h0, 1'b0, 1'b0, 1'b0, 20'h00010, 16'ha55a}, '{2'h3, 1'b0, 1'b0, 1'b0, 20'h40012, 16'h0034},
		'{2'h2, 1'b0, 1'b0, 1'b0, 20'h00014, 16'hbe00}, '{2'h1, 1'b0, 1'b0, 1'b0, 20'h00006, 16'hc3c3}};

	ebsp_top #(.WIDE_BUS(1'b1)) ebsp_top_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cyc_req_i(cyc_req),
		.cyc_addr_i(cyc_addr), .cyc_write_i(cyc_write), .cyc_bhe_n_i(cyc_bhe_n), .cyc_space_i(cyc_space),
		.cyc_mid3_i(cyc_mid3), .cyc_wdata_i(cyc_wdata), .cyc_busy_o(busy), .cyc_done_o(done),
		.cyc_rdata_o(cyc_rdata), .pcb_sel_i(pcb_sel), .pcb_wr_i(pcb_wr), .pcb_byte_i(pcb_byte),
		.pcb_offset_i(pcb_offset), .pcb_wdata_i(pcb_wdata), .pcb_rdata_o(pcb_rdata), .a_bus_o(a_bus),
		.a_bus_oe_n_o(a_oe_n), .ad_o(ad_out), .ad_oe_n_o(ad_oe_n), .ad_i(ad_in), .ready_i(ready),
		.bhe_n_o(bhe_n), .wr_n_o(wr_n), .high_byte_write_enable_n_o(hwe_n), .low_byte_write_enable_n_o(lwe_n),
		.byte_write_strobe_n_o(wb_n), .byte_write_strobe_oe_n_o(wb_oe_n), .low_memory_select_n_o(lsel_n),
		.midrange_select_three_n_o(mid3_n), .bus_width8_o(w8));

	// Narrow part in lockstep on the same stimulus
	ebsp_top #(.WIDE_BUS(1'b0)) ebsp_top_narrow_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cyc_req_i(cyc_req),
		.cyc_addr_i(cyc_addr), .cyc_write_i(cyc_write), .cyc_bhe_n_i(cyc_bhe_n), .cyc_space_i(cyc_space),
		.cyc_mid3_i(cyc_mid3), .cyc_wdata_i(cyc_wdata), .cyc_busy_o(), .cyc_done_o(),
		.cyc_rdata_o(), .pcb_sel_i(pcb_sel), .pcb_wr_i(pcb_wr), .pcb_byte_i(pcb_byte),
		.pcb_offset_i(pcb_offset), .pcb_wdata_i(pcb_wdata), .pcb_rdata_o(pcb_rdata8), .a_bus_o(),
		.a_bus_oe_n_o(), .ad_o(), .ad_oe_n_o(), .ad_i(ad_in), .ready_i(ready),
		.bhe_n_o(), .wr_n_o(), .high_byte_write_enable_n_o(), .low_byte_write_enable_n_o(),
		.byte_write_strobe_n_o(wb8_n), .byte_write_strobe_oe_n_o(), .low_memory_select_n_o(),
		.midrange_select_three_n_o(), .bus_width8_o(w8n));

	ebsp_mem_model ebsp_mem_model_i (.ref_clk_i(ref_clk_i), .a_bus_i(a_bus), .a_oe_n_i(a_oe_n), .ad_i(ad_out),
		.ad_oe_n_i(ad_oe_n), .wr_n_i(wr_n), .hwe_n_i(hwe_n), .lwe_n_i(lwe_n), .lcs_n_i(lsel_n), .slow_i(slow), .ad_o(ad_in),
		.ready_o(ready));

	always #12.5 ref_clk_i = ~ref_clk_i;

	// ****************************************
	// Request release and run limit
	// ****************************************
	always @(posedge ref_clk_i)
	begin
		cycles++;
		// Taken cycle, not a refresh, releases the request
		if (busy === 1'b1 && a_oe_n === 1'b0)
			cyc_req <= 1'b0;
		if (cycles == 5000)
		begin
			miscompares++;
			end_of_test();
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// One read or write, word or byte, to the register block
	task automatic reg_io(input logic w, input logic b, input logic [7:0] ofs, input logic [15:0] wd);
		@(posedge ref_clk_i);
		pcb_sel <= 1'b1;
		pcb_wr <= w;
		pcb_byte <= b;
		pcb_offset <= ofs;
		pcb_wdata <= wd;
		@(posedge ref_clk_i);
		pcb_sel <= 1'b0;
		@(negedge ref_clk_i);
		@(negedge ref_clk_i);
		rd = pcb_rdata;
		rd8 = pcb_rdata8;
	endtask

	// One bus cycle; leaves its length in n and busy at done in bz
	task automatic cyc(input ebsp_row_t r);
		logic [19:0] pa;
		logic [4:0] ps;
		logic x8;
		logic [1:0] pn;
		x8 = (r.sp == 2'h1) ? aux[2] : (r.sp == 2'h2) ? aux[1] : (r.sp == 2'h3) ? aux[0] : 1'b0;
		while (busy !== 1'b0)
			@(negedge ref_clk_i);
		@(posedge ref_clk_i);
		cyc_req <= 1'b1;
		cyc_space <= r.sp;
		cyc_write <= r.w;
		cyc_bhe_n <= r.bhe_n;
		cyc_mid3 <= r.mid3;
		cyc_addr <= r.adr;
		cyc_wdata <= r.wd;
		k = 0;
		do
		begin
			@(negedge ref_clk_i);
			k++;
			if (ad_oe_n !== 1'b0)
			begin
				pa = a_bus;
				ps = {hwe_n, lwe_n, x8 ? w8 : w8, mid3_n, lsel_n};
				pn = {w8n, wb8_n};
			end
		end
		while (ad_oe_n !== 1'b0 && k < 20);
		chk(pa, r.adr);
		chk({4'h0, ad_out}, {4'h0, r.adr[15:0]});
		chk({15'h0, ps}, {15'h0, r.bhe_n | !r.w, r.adr[0] | !r.w, x8, !(r.mid3 && !pseudo_static_mode_enable), r.sp != 2'h1});
		chk({18'h0, pn}, {18'h0, 1'b1, !r.w});
		n = 0;
		do
		begin
			@(negedge ref_clk_i);
			n++;
		end
		while (done !== 1'b1 && n < 40);
		bz = busy;
		if (!r.w)
			chk({4'h0, cyc_rdata}, {4'h0, r.wd});
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (5) @(posedge ref_clk_i);
		chk({wr_n, lsel_n, mid3_n, wb_oe_n}, 20'hf);
		arst_n_i <= 1'b1;
		reg_io(1'b0, 1'b0, ebsp_pkg::OFS_LOW_MEMORY_SELECT_CONTROL, 16'h0000);
		chk(rd, 20'h0);
		reg_io(1'b1, 1'b0, 8'ha3, 16'h0007);
		reg_io(1'b1, 1'b0, 8'h10, 16'hffff);
		reg_io(1'b0, 1'b0, 8'h10, 16'h0000);
		chk(rd, 20'h0);
		reg_io(1'b0, 1'b0, ebsp_pkg::OFS_LOW_MEMORY_SELECT_CONTROL, 16'h0000);
		chk(rd, 20'h0);
		reg_io(1'b1, 1'b0, ebsp_pkg::OFS_REFRESH_CLOCK_PRESCALER, 16'habcd);
		reg_io(1'b1, 1'b1, ebsp_pkg::OFS_REFRESH_CLOCK_PRESCALER, 16'h1234);
		reg_io(1'b0, 1'b0, ebsp_pkg::OFS_REFRESH_CLOCK_PRESCALER, 16'h0000);
		chk(rd, 20'hab34);
		chk(rd8, 20'h1234);
		reg_io(1'b1, 1'b0, ebsp_pkg::OFS_AUXILIARY_CONFIGURATION, {13'h0, aux});
		reg_io(1'b0, 1'b0, ebsp_pkg::OFS_AUXILIARY_CONFIGURATION, 16'h0000);
		chk(rd, 20'h6);
		foreach (rows[i])
		begin
			cyc(rows[i]);
			if (i == 0)
				n0 = n;
			chk(20'(n), 20'(n0));
		end
		// Late ready stretches a low space cycle, ignored ready does not
		slow = 1'b1;
		cyc(rows[7]);
		chk(20'(n > n0), 20'h1);
		reg_io(1'b1, 1'b0, ebsp_pkg::OFS_LOW_MEMORY_SELECT_CONTROL, 16'h0005);
		cyc(rows[7]);
		chk(20'(n), 20'(n0 + 1));
		cyc('{2'h3, 1'b1, 1'b1, 1'b1, 20'h40020, 16'h0000});
		// Pseudo-static mode on, refresh unit still off
		reg_io(1'b1, 1'b0, ebsp_pkg::OFS_LOW_MEMORY_SELECT_CONTROL, 16'h0045);
		pseudo_static_mode_enable = 1'b1;
		cyc('{2'h3, 1'b1, 1'b1, 1'b1, 20'h40020, 16'h0000});
		cyc(rows[7]);
		chk({19'h0, bz}, 20'h1);
		@(negedge ref_clk_i);
		chk({19'h0, busy}, 20'h0);
		cyc(rows[4]);
		chk({19'h0, bz}, 20'h0);
		k = 0;
		repeat (60) @(negedge ref_clk_i) k += int'(mid3_n !== 1'b1);
		chk(20'(k), 20'h0);
		// Refresh running at the shortest interval
		// No refresh address counter here, so no select or address is driven during a refresh
		reg_io(1'b1, 1'b0, ebsp_pkg::OFS_REFRESH_CLOCK_PRESCALER, ebsp_pkg::REFRESH_RELOAD_MIN);
		reg_io(1'b1, 1'b0, ebsp_pkg::OFS_REFRESH_UNIT_ENABLE, 16'h8000);
		reg_io(1'b0, 1'b0, ebsp_pkg::OFS_REFRESH_UNIT_ENABLE, 16'h0000);
		chk({19'h0, rd[15]}, 20'h1);
		t = 0;
		while (mid3_n !== 1'b0 && t < 60)
		begin
			@(negedge ref_clk_i);
			t++;
		end
		t = 0;
		k = 0;
		while (mid3_n === 1'b0 && t < 40)
		begin
			chk({lsel_n, a_oe_n}, 20'h3);
			k++;
			t++;
			@(negedge ref_clk_i);
		end
		while (mid3_n !== 1'b0 && t < 40)
		begin
			t++;
			@(negedge ref_clk_i);
		end
		chk(20'(k), 20'(ebsp_pkg::REF_TICKS));
		chk(20'(t), 20'(ebsp_pkg::REFRESH_RELOAD_MIN) + 20'h1);
		cyc(rows[7]);
		// Reset in mid-run clears the mode and the strobe
		@(posedge ref_clk_i);
		arst_n_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		chk({mid3_n, wb_oe_n, lsel_n}, 20'h7);
		arst_n_i <= 1'b1;
		reg_io(1'b0, 1'b0, ebsp_pkg::OFS_LOW_MEMORY_SELECT_CONTROL, 16'h0000);
		chk(rd, 20'h0);
		end_of_test();
	end
endmodule
